// [dwic_defines.vh]
// register offsets, field positions, reset values and timing counts of the watchdog core
`ifndef DWIC_DEFINES_VH
`define DWIC_DEFINES_VH
`define DWIC_OFS_ID        8'h00
`define DWIC_OFS_CLEAR     8'h01
`define DWIC_OFS_STATUS    8'h02
`define DWIC_OFS_IRQEN     8'h03
`define DWIC_OFS_REV       8'h04
`define DWIC_OFS_FILTER    8'h08
`define DWIC_OFS_CLKSEL    8'h14
`define DWIC_OFS_TOEN      8'h15
`define DWIC_OFS_EXPSTAT   8'h17
`define DWIC_OFS_TIMEOUT   8'h18
`define DWIC_OFS_LEVELS    8'h48
`define DWIC_OFS_ROUTE     8'h49
`define DWIC_OFS_RISE      8'h42
`define DWIC_OFS_FALL      8'h43
`define DWIC_OFS_FLTEN     8'h44
`define DWIC_PORT_STRIDE   8'h10
`define DWIC_PORT_LAST     4'hb
`define DWIC_CLR_IRQ       6
`define DWIC_CLR_RESTART   5
`define DWIC_CLR_EFFECT    4
`define DWIC_CLR_EDGE      3
`define DWIC_CLR_OVR       2
`define DWIC_ST_WDT        5
`define DWIC_ST_FALL       4
`define DWIC_ST_RISE       3
`define DWIC_ST_IRQ        2
`define DWIC_ST_OVR        1
`define DWIC_ST_EDGE       0
`define DWIC_EN_MASTER     2
`define DWIC_FILTER_W      20
`define DWIC_CLK_MHZ       50
`define DWIC_WDT_TICK_NS   100
`define DWIC_FLT_TICK_NS   200
`define DWIC_WDT_TICK_CYC  ((`DWIC_WDT_TICK_NS * `DWIC_CLK_MHZ) / 1000)
`define DWIC_FLT_TICK_CYC  ((`DWIC_FLT_TICK_NS * `DWIC_CLK_MHZ) / 1000)
`define DWIC_RST_BYTE      8'h00
`define DWIC_RST_WORD      32'h0000_0000
`endif

// [dwic_tick_div.v]
// divider that makes a one-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module dwic_tick_div #(
	parameter DIV = 5              // cycles per tick
) (
	input  wire ref_clk,           // system clock
	input  wire reset,             // sync reset, active high
	output reg  tick               // one-cycle enable pulse
);
	reg [7:0] cnt_q;               // cycle counter

	// free-running count, pulse on wrap
	always @(posedge ref_clk) begin
		if (reset) begin
			cnt_q <= 8'h00;
			tick  <= 1'b0;
		end else if (cnt_q == DIV - 1) begin
			cnt_q <= 8'h00;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			tick  <= 1'b0;
		end
	end
endmodule

// [dwic_line_filter.v]
// glitch filter for one input line: new level accepted after a stable interval
`timescale 1ns/1ps
`include "dwic_defines.vh"
module dwic_line_filter #(
	parameter FW = 20              // interval width
) (
	input  wire          ref_clk,  // system clock
	input  wire          reset,    // sync reset, active high
	input  wire          tick,     // 200 ns step enable
	input  wire          enable,   // filtering on for this line
	input  wire [FW-1:0] interval, // shared interval in steps
	input  wire          raw,      // unfiltered line
	output reg           clean     // filtered line
);
	reg [FW-1:0] cnt_q;            // steps the raw level has differed

	// count stable steps of a differing level; bypass when disabled
	always @(posedge ref_clk) begin
		if (reset) begin
			cnt_q <= {FW{1'b0}};
			clean <= 1'b0;
		end else if (!enable || raw == clean) begin
			cnt_q <= {FW{1'b0}};
			clean <= raw;
		end else if (tick) begin
			if (cnt_q >= interval) begin
				clean <= raw;
				cnt_q <= {FW{1'b0}};
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

// [dwic_core.v]
// watchdog, change detection and interrupt control core of a static digital i/o board
//
// Contract
// - per-port expiry level register, one bit per line
// - port registers at base plus 0x10 times port
// - per-port trigger route enable, one bit per line
// - routing only first output port, plus star line
// - read-only identity byte at offset zero
// - clear bit 6 clears watchdog interrupt
// - clear bit 5 restarts watchdog count
// - clear bit 4 cancels expiry effects
// - clear bit 3 clears edge flag, detectors
// - overflow clears only with bits 2 and 3
// - status bits 5,4,3 set regardless of interrupt enables
// - status bit 2 shows interrupt asserted
// - status bit 1 on further edge during interrupt
// - interrupt enables, master bit 2 gates all
// - read-only 32-bit revision word
// - 20-bit filter interval in 200 ns steps
// - clock flag: 0 backplane, 1 onboard
// - write-only auto clock select disable
// - timeout enable allows expiry output states
// - expiry status reads 1 while expired
// - 32-bit timeout in 100 ns units
// - per-line filter enable, shared interval
// - per-line rising edge monitor enable
`timescale 1ns/1ps
`include "dwic_defines.vh"
module dwic_core #(
	parameter NPORT    = 12,            // ports fitted
	parameter BOARD_ID = 8'h5a,         // arbitrary value
	parameter REVISION = 32'h0001_0000, // arbitrary value
	parameter OUT_PORT = 0,             // first output-enabled port
	parameter STAR_PORT = 1,            // second output-enabled port
	parameter BACKPLANE = 1             // 1 on backplane variants
) (
	input  wire               ref_clk,          // 50 MHz system clock
	input  wire               reset,            // sync reset, active high
	input  wire [7:0]         reg_addr,         // register byte offset
	input  wire               reg_wr,           // write strobe
	input  wire               reg_rd,           // read strobe
	input  wire [31:0]        reg_wdata,        // write data
	output reg  [31:0]        reg_rdata,        // read data, registered
	input  wire               onboard_clk_used, // 1 when onboard oscillator runs system
	output wire               auto_clock_select_off, // forces onboard clock
	input  wire [8*NPORT-1:0] line_in,          // raw port lines
	output wire [8*NPORT-1:0] line_out,         // port lines with expiry override
	input  wire [8*NPORT-1:0] line_drive,       // normal output levels
	output wire [8:0]         trigger_out,      // trigger bus lines 0..7, star at 8
	output wire               expiry_state_flag,// watchdog expiry held
	output wire               irq               // interrupt request, active high
);
	localparam NL = 8 * NPORT;              // total lines
	localparam FW = `DWIC_FILTER_W;         // filter width

	// register state
	reg  [7:0]    irq_en_q;                 // interrupt enables
	reg  [FW-1:0] glitch_filter_interval_q; // shared filter interval
	reg           auto_off_q;               // automatic clock choice disabled
	reg           timeout_action_enable_q;  // expiry states allowed
	reg  [31:0]   timeout_count_q;          // timeout setting
	reg  [NL-1:0] expiry_line_level_q;      // per-line expiry level
	reg  [NL-1:0] trigger_route_enable_q;   // per-line route enable
	reg  [NL-1:0] rising_monitor_enable_q;  // per-line rising monitor
	reg  [NL-1:0] falling_monitor_enable_q; // per-line falling monitor
	reg  [NL-1:0] line_filter_enable_q;     // per-line filter enable

	// status state
	reg           wdt_st_q;                 // watchdog expiry status
	reg           fall_st_q;                // falling edge seen
	reg           rise_st_q;                // rising edge seen
	reg           edge_st_q;                // any edge seen
	reg           ovr_st_q;                 // further edge during interrupt
	reg           expired_q;                // expiry state held
	reg  [31:0]   wdt_cnt_q;                // watchdog down counter
	reg  [NL-1:0] prev_q;                   // last filtered line levels

	wire          wdt_tick;                 // 100 ns enable
	wire          flt_tick;                 // 200 ns enable
	wire [NL-1:0] clean;                    // filtered lines

	dwic_tick_div #(.DIV(`DWIC_WDT_TICK_CYC)) u_wdt_div (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (wdt_tick)
	);

	dwic_tick_div #(.DIV(`DWIC_FLT_TICK_CYC)) u_flt_div (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (flt_tick)
	);

	// one filter per line, all sharing the interval
	genvar gi;
	generate
		for (gi = 0; gi < NL; gi = gi + 1) begin : g_flt
			dwic_line_filter #(.FW(FW)) u_flt (
				.ref_clk  (ref_clk),
				.reset    (reset),
				.tick     (flt_tick),
				.enable   (line_filter_enable_q[gi]),
				.interval (glitch_filter_interval_q),
				.raw      (line_in[gi]),
				.clean    (clean[gi])
			);
		end
	endgenerate

	// address decode: port number in the upper nibble for per-port space
	// port offsets above the fitted count fall through and read as zero
	wire [3:0] port_n   = reg_addr[7:4] - 4'h4;
	wire [3:0] port_reg = reg_addr[3:0];
	wire       port_hit = (reg_addr >= 8'h40) && (port_n <= `DWIC_PORT_LAST)
		&& (port_n < NPORT);
	wire [7:0] port_base = {4'h4, port_reg};

	// clear strobes exist only in the write cycle itself
	// nothing is stored, so a later write cannot replay an old clear
	wire clr_wr  = reg_wr && (reg_addr == `DWIC_OFS_CLEAR);
	wire c_irq   = clr_wr && reg_wdata[`DWIC_CLR_IRQ];
	wire c_rst   = clr_wr && reg_wdata[`DWIC_CLR_RESTART];
	wire c_eff   = clr_wr && reg_wdata[`DWIC_CLR_EFFECT];
	wire c_edge  = clr_wr && reg_wdata[`DWIC_CLR_EDGE];
	wire c_ovr   = c_edge && reg_wdata[`DWIC_CLR_OVR];

	// edge detection on filtered, monitored lines
	// detectors see filtered levels, so a rejected glitch raises no flag
	wire [NL-1:0] rise_v = clean & ~prev_q & rising_monitor_enable_q;
	wire [NL-1:0] fall_v = ~clean & prev_q & falling_monitor_enable_q;
	wire          rise_ev = |rise_v;
	wire          fall_ev = |fall_v;
	wire          edge_ev = rise_ev | fall_ev;
	wire          wdt_ev  = wdt_tick && !expired_q && (wdt_cnt_q == 32'h0000_0001);

	// interrupt sources gated by their enables and the master enable
	wire irq_src = (wdt_st_q && irq_en_q[`DWIC_ST_WDT]) ||
		(fall_st_q && irq_en_q[`DWIC_ST_FALL]) ||
		(rise_st_q && irq_en_q[`DWIC_ST_RISE]) ||
		(ovr_st_q  && irq_en_q[`DWIC_ST_OVR]) ||
		(edge_st_q && irq_en_q[`DWIC_ST_EDGE]);
	assign irq = irq_src && irq_en_q[`DWIC_EN_MASTER];

	// per-port register writes
	integer p;
	always @(posedge ref_clk) begin
		if (reset) begin
			expiry_line_level_q      <= {NL{1'b0}};
			trigger_route_enable_q   <= {NL{1'b0}};
			rising_monitor_enable_q  <= {NL{1'b0}};
			falling_monitor_enable_q <= {NL{1'b0}};
			line_filter_enable_q     <= {NL{1'b0}};
		end else if (reg_wr && port_hit) begin
			for (p = 0; p < NPORT; p = p + 1) begin
				if (port_n == p) begin
					case (port_base)
						`DWIC_OFS_LEVELS: expiry_line_level_q[8*p +: 8] <= reg_wdata[7:0];
						`DWIC_OFS_ROUTE:  trigger_route_enable_q[8*p +: 8] <= reg_wdata[7:0];
						`DWIC_OFS_RISE:   rising_monitor_enable_q[8*p +: 8] <= reg_wdata[7:0];
						`DWIC_OFS_FALL:   falling_monitor_enable_q[8*p +: 8] <= reg_wdata[7:0];
						`DWIC_OFS_FLTEN:  line_filter_enable_q[8*p +: 8] <= reg_wdata[7:0];
						default: ;
					endcase
				end
			end
		end
	end

	// shared control registers
	always @(posedge ref_clk) begin
		if (reset) begin
			irq_en_q                 <= `DWIC_RST_BYTE;
			glitch_filter_interval_q <= {FW{1'b0}};
			auto_off_q               <= 1'b0;
			timeout_action_enable_q  <= 1'b0;
			timeout_count_q          <= `DWIC_RST_WORD;
		end else if (reg_wr) begin
			case (reg_addr)
				`DWIC_OFS_IRQEN:   irq_en_q <= {2'b00, reg_wdata[5:0]};
				`DWIC_OFS_FILTER:  glitch_filter_interval_q <= reg_wdata[FW-1:0];
				`DWIC_OFS_CLKSEL:  auto_off_q <= reg_wdata[0];
				`DWIC_OFS_TOEN:    timeout_action_enable_q <= reg_wdata[0];
				`DWIC_OFS_TIMEOUT: timeout_count_q <= reg_wdata;
				default: ;
			endcase
		end
	end
	assign auto_clock_select_off = auto_off_q;

	// watchdog counter; held at zero while expired until restarted
	// a zero count never expires, so software must restart once to arm it
	always @(posedge ref_clk) begin
		if (reset) begin
			wdt_cnt_q <= `DWIC_RST_WORD;
			expired_q <= 1'b0;
		end else begin
			if (c_rst) begin
				wdt_cnt_q <= timeout_count_q;
			end else if (wdt_tick && wdt_cnt_q != 32'h0000_0000) begin
				wdt_cnt_q <= wdt_cnt_q - 32'h0000_0001;
			end
			// expiry wins over a clear in the same cycle
			if (wdt_ev) begin
				expired_q <= 1'b1;
			end else if (c_eff) begin
				expired_q <= 1'b0;
			end
		end
	end
	assign expiry_state_flag = expired_q;

	// sticky status flags: a new event beats a clear in the same cycle
	always @(posedge ref_clk) begin
		if (reset) begin
			wdt_st_q  <= 1'b0;
			fall_st_q <= 1'b0;
			rise_st_q <= 1'b0;
			edge_st_q <= 1'b0;
			ovr_st_q  <= 1'b0;
			prev_q    <= {NL{1'b0}};
		end else begin
			prev_q <= clean;                                   // detector history
			if (wdt_ev) begin
				wdt_st_q <= 1'b1;
			end else if (c_irq) begin
				wdt_st_q <= 1'b0;
			end
			if (fall_ev) begin
				fall_st_q <= 1'b1;
			end else if (c_edge) begin
				fall_st_q <= 1'b0;
			end
			if (rise_ev) begin
				rise_st_q <= 1'b1;
			end else if (c_edge) begin
				rise_st_q <= 1'b0;
			end
			if (edge_ev) begin
				edge_st_q <= 1'b1;
			end else if (c_edge) begin
				edge_st_q <= 1'b0;
			end
			if (edge_ev && irq && edge_st_q) begin
				ovr_st_q <= 1'b1;
			end else if (c_ovr) begin
				ovr_st_q <= 1'b0;
			end
		end
	end

	// expiry override of the output levels; only when actions are enabled
	wire take_over = expired_q && timeout_action_enable_q;
	assign line_out = take_over ? expiry_line_level_q : line_drive;

	// trigger routing honoured only on the allowed port lines
	// other ports keep their stored enables but never reach the bus
	wire [7:0] route_main = trigger_route_enable_q[8*OUT_PORT +: 8] &
		line_out[8*OUT_PORT +: 8];
	wire       route_star = (BACKPLANE != 0) && trigger_route_enable_q[8*STAR_PORT] &&
		line_out[8*STAR_PORT];
	assign trigger_out = {route_star, route_main};

	// status byte assembled from live flags
	wire [7:0] status_byte = {2'b00, wdt_st_q, fall_st_q, rise_st_q, irq, ovr_st_q,
		edge_st_q};

	// read mux, registered; unmapped and write-only addresses read zero
	// registered data costs a cycle of latency but keeps the bus path short
	integer r;
	always @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= `DWIC_RST_WORD;
		end else if (reg_rd) begin
			reg_rdata <= `DWIC_RST_WORD;
			case (reg_addr)
				`DWIC_OFS_ID:      reg_rdata <= {24'h000000, BOARD_ID};
				`DWIC_OFS_STATUS:  reg_rdata <= {24'h000000, status_byte};
				`DWIC_OFS_IRQEN:   reg_rdata <= {24'h000000, irq_en_q};
				`DWIC_OFS_REV:     reg_rdata <= REVISION;
				`DWIC_OFS_FILTER:  reg_rdata <= {12'h000, glitch_filter_interval_q};
				`DWIC_OFS_CLKSEL:  reg_rdata <= {30'h0, onboard_clk_used, 1'b0};
				`DWIC_OFS_TOEN:    reg_rdata <= {31'h0, timeout_action_enable_q};
				`DWIC_OFS_EXPSTAT: reg_rdata <= {31'h0, expired_q};
				`DWIC_OFS_TIMEOUT: reg_rdata <= timeout_count_q;
				default: begin
					if (port_hit) begin
						for (r = 0; r < NPORT; r = r + 1) begin
							if (port_n == r) begin
								case (port_base)
									`DWIC_OFS_LEVELS: reg_rdata <= {24'h0, expiry_line_level_q[8*r +: 8]};
									`DWIC_OFS_ROUTE:  reg_rdata <= {24'h0, trigger_route_enable_q[8*r +: 8]};
									`DWIC_OFS_RISE:   reg_rdata <= {24'h0, rising_monitor_enable_q[8*r +: 8]};
									`DWIC_OFS_FALL:   reg_rdata <= {24'h0, falling_monitor_enable_q[8*r +: 8]};
									`DWIC_OFS_FLTEN:  reg_rdata <= {24'h0, line_filter_enable_q[8*r +: 8]};
									default: ;
								endcase
							end
						end
					end
				end
			endcase
		end
	end
endmodule

// [dwic_core_assertions.sv]
// port-level checker for the watchdog core, bound to every core instance
`timescale 1ns/1ps
module dwic_core_assertions #(
	parameter NPORT    = 12,            // ports fitted
	parameter BOARD_ID = 8'h5a,         // arbitrary value
	parameter REVISION = 32'h0001_0000  // arbitrary value
) (
	input wire               ref_clk,           // system clock
	input wire               reset,             // sync reset, active high
	input wire [7:0]         reg_addr,          // register offset
	input wire               reg_wr,            // write strobe
	input wire               reg_rd,            // read strobe
	input wire [31:0]        reg_wdata,         // write data
	input wire [31:0]        reg_rdata,         // read data
	input wire               onboard_clk_used,  // clock source level
	input wire [8*NPORT-1:0] line_out,          // lines as driven
	input wire [8*NPORT-1:0] line_drive,        // normal levels
	input wire [8:0]         trigger_out,       // trigger lines
	input wire               expiry_state_flag, // expiry held
	input wire               irq                // interrupt request
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// identity and revision are constants whatever was written before
	id_read_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == BOARD_ID)
		else $error("identity byte wrong");
	rev_read_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == REVISION)
		else $error("revision word wrong");
	// the strobe register stores nothing, so it must read back empty
	clear_read_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == 32'h0)
		else $error("clear register read nonzero");
	clk_flag_a: assert property (reg_rd && reg_addr == 8'h14 |=>
		reg_rdata == {30'h0, $past(onboard_clk_used), 1'b0})
		else $error("clock selection read wrong");
	exp_read_a: assert property (reg_rd && reg_addr == 8'h17 |=>
		reg_rdata == {31'h0, $past(expiry_state_flag)})
		else $error("expiry status read wrong");
	irq_read_a: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[2] == $past(irq))
		else $error("interrupt status bit wrong");
	master_gate_a: assert property (reg_wr && reg_addr == 8'h03 && !reg_wdata[2] |=> !irq)
		else $error("interrupt without master enable");
	// outside expiry the override path must be transparent
	normal_pass_a: assert property (!expiry_state_flag |-> line_out == line_drive)
		else $error("lines overridden outside expiry");
	trig_route_a: assert property ((trigger_out[7:0] & ~line_out[7:0]) == 8'h00
		&& (!trigger_out[8] || line_out[8]))
		else $error("trigger line not backed by its port line");
	cover property ($rose(expiry_state_flag));
	cover property ($rose(irq));
	cover property (reg_rd && reg_addr == 8'h17);
endmodule

bind dwic_core dwic_core_assertions #(.NPORT(NPORT), .BOARD_ID(BOARD_ID), .REVISION(REVISION))
	dwic_core_assertions_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.onboard_clk_used(onboard_clk_used), .line_out(line_out), .line_drive(line_drive),
	.trigger_out(trigger_out), .expiry_state_flag(expiry_state_flag), .irq(irq));

// [dwic_host_model.sv]
// host software model: one-cycle register strobes on the core's bus
`timescale 1ns/1ps
module dwic_host_model (
	input  wire        ref_clk,   // system clock
	output reg  [7:0]  reg_addr,  // register offset
	output reg         reg_wr,    // write strobe
	output reg         reg_rd,    // read strobe
	output reg  [31:0] reg_wdata  // write data
);
	// bus idle from time zero so reset sees no stray strobe
	initial begin
		reg_addr = 8'hff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end
	// write launched just after an edge, taken at the next one
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			#1;
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(posedge ref_clk);
			#1;
			reg_wr = 1'b0;
			reg_wdata = ~d; // released data is garbage, not last value
		end
	endtask
	// read strobe; data shows the cycle after
	task rd(input [7:0] a);
		begin
			@(posedge ref_clk);
			#1;
			reg_addr = a;
			reg_rd = 1'b1;
			@(posedge ref_clk);
			#1;
			reg_rd = 1'b0;
			reg_addr = ~a;
		end
	endtask
	// keep-alive write, issued well inside the timeout
	task kick;
		wr(8'h01, 32'h20);
	endtask
endmodule

// [dwic_testbench.sv]
// self-checking bench for the watchdog core with a read scoreboard
`timescale 1ns/1ps
module testbench;
	reg         ref_clk;           // 50 MHz clock
	reg         reset;             // sync reset
	reg         onboard_clk_used;  // clock source level
	reg  [95:0] line_in;           // raw lines
	reg  [95:0] line_drive;        // normal levels
	wire [7:0]  reg_addr;          // from host
	wire        reg_wr;            // from host
	wire        reg_rd;            // from host
	wire [31:0] reg_wdata;         // from host
	wire [31:0] reg_rdata;         // read data
	wire        auto_clock_select_off; // clock override
	wire [95:0] line_out;          // driven lines
	wire [8:0]  trigger_out;       // trigger lines
	wire        expiry_state_flag; // expiry held
	wire        irq;               // interrupt
	integer     seed, bad_count, cmp_count, i;
	reg  [31:0] exp_q[$], msk_q[$], e, m; // expected reads, scoreboard only
	reg  [31:0] v;                 // random register value of the main thread
	reg         rd_d;              // read issued last cycle
	reg  [7:0]  lv[0:11], rt[0:11];// written port values
	dwic_host_model dwic_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	dwic_core dwic_core_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.onboard_clk_used(onboard_clk_used), .auto_clock_select_off(auto_clock_select_off),
		.line_in(line_in), .line_out(line_out), .line_drive(line_drive),
		.trigger_out(trigger_out), .expiry_state_flag(expiry_state_flag), .irq(irq));
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;
	// scoreboard: take the oldest note whenever read data appears
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			cmp_count = cmp_count + 1;
			if ((reg_rdata & m) !== (e & m)) begin
				bad_count = bad_count + 1;
				$display("Error at %0t: read %h want %h", $time, reg_rdata & m, e & m);
			end
		end
	end
	task chk_rd(input [7:0] a, input [31:0] x, input [31:0] k);
		begin
			exp_q.push_back(x);
			msk_q.push_back(k);
			dwic_host_model_i.rd(a);
		end
	endtask
	task pin(input ok);
		begin
			cmp_count = cmp_count + 1;
			if (ok !== 1'b1) begin
				bad_count = bad_count + 1;
				$display("Error at %0t: port value wrong", $time);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// watchdog: whole run is a few hundred cycles
	initial begin
		#400000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	initial begin
		seed = 16457;
		bad_count = 0;
		cmp_count = 0;
		reset = 1'b1;
		onboard_clk_used = 1'b1;
		line_drive = {$random(seed), $random(seed), $random(seed)};
		line_in = {$random(seed), $random(seed), $random(seed)} & ~96'h3;
		repeat (12) @(posedge ref_clk);
		#1 reset = 1'b0;
		// constants, reset values and refused places
		chk_rd(8'h00, 32'h5a, 32'hffffffff);
		chk_rd(8'h04, 32'h00010000, 32'hffffffff);
		chk_rd(8'h14, 32'h2, 32'hffffffff);
		chk_rd(8'h01, 32'h0, 32'hffffffff);
		chk_rd(8'h18, 32'h0, 32'hffffffff);
		chk_rd(8'h07, 32'h0, 32'hffffffff);
		dwic_host_model_i.wr(8'h14, 32'h1);
		pin(auto_clock_select_off === 1'b1);
		$display("test constants done");
		// per-port registers at base plus stride, random content
		for (i = 0; i < 12; i = i + 1) begin
			lv[i] = $random(seed);
			rt[i] = $random(seed);
			dwic_host_model_i.wr(8'h48 + 8'h10 * i, {24'h0, lv[i]});
			dwic_host_model_i.wr(8'h49 + 8'h10 * i, {24'h0, rt[i]});
		end
		for (i = 0; i < 12; i = i + 1) begin
			chk_rd(8'h48 + 8'h10 * i, {24'h0, lv[i]}, 32'hff);
			chk_rd(8'h49 + 8'h10 * i, {24'h0, rt[i]}, 32'hff);
		end
		v = $random(seed);
		dwic_host_model_i.wr(8'h08, v);
		chk_rd(8'h08, v, 32'hfffff);
		v = $random(seed);
		dwic_host_model_i.wr(8'h18, v);
		chk_rd(8'h18, v, 32'hffffffff);
		$display("test registers done");
		// watchdog: keep alive, then expire into the stored levels
		dwic_host_model_i.wr(8'h18, 32'h4);
		dwic_host_model_i.wr(8'h15, 32'h1);
		for (i = 0; i < 6; i = i + 1) begin
			dwic_host_model_i.kick;
			repeat (8) @(posedge ref_clk);
			#1 pin(expiry_state_flag === 1'b0);
		end
		dwic_host_model_i.kick;
		repeat (12) @(posedge ref_clk);
		#1 pin(expiry_state_flag === 1'b0);
		for (i = 0; i < 20 && expiry_state_flag !== 1'b1; i = i + 1) @(posedge ref_clk);
		#1 pin(expiry_state_flag === 1'b1);
		for (i = 0; i < 12; i = i + 1) pin(line_out[8*i +: 8] === lv[i]);
		pin(trigger_out[7:0] === (lv[0] & rt[0]));
		pin(trigger_out[8] === (lv[1][0] & rt[1][0]));
		dwic_host_model_i.wr(8'h03, 32'h20);
		pin(irq === 1'b0);
		dwic_host_model_i.wr(8'h03, 32'h24);
		pin(irq === 1'b1);
		chk_rd(8'h02, 32'h24, 32'h24);
		chk_rd(8'h17, 32'h1, 32'hff);
		dwic_host_model_i.wr(8'h01, 32'h40);
		chk_rd(8'h02, 32'h0, 32'h24);
		pin(expiry_state_flag === 1'b1);
		dwic_host_model_i.wr(8'h01, 32'h10);
		pin(expiry_state_flag === 1'b0);
		pin(line_out === line_drive);
		chk_rd(8'h17, 32'h0, 32'hff);
		// expiry without timeout action leaves the lines alone
		dwic_host_model_i.wr(8'h15, 32'h0);
		dwic_host_model_i.kick;
		repeat (30) @(posedge ref_clk);
		chk_rd(8'h02, 32'h20, 32'h20);
		pin(line_out === line_drive);
		dwic_host_model_i.wr(8'h01, 32'h50);
		$display("test watchdog done");
		// change detection, overflow and the paired clear
		dwic_host_model_i.wr(8'h03, 32'h05);
		dwic_host_model_i.wr(8'h42, 32'h03);
		dwic_host_model_i.wr(8'h43, 32'h01);
		line_in[0] = 1'b1;
		repeat (4) @(posedge ref_clk);
		chk_rd(8'h02, 32'h0d, 32'h1f);
		line_in[0] = 1'b0;
		repeat (4) @(posedge ref_clk);
		chk_rd(8'h02, 32'h1f, 32'h1f);
		dwic_host_model_i.wr(8'h01, 32'h08);
		chk_rd(8'h02, 32'h02, 32'h03);
		dwic_host_model_i.wr(8'h01, 32'h0c);
		chk_rd(8'h02, 32'h0, 32'h03);
		$display("test edges done");
		// filtered line: a short glitch is dropped, a long level passes
		dwic_host_model_i.wr(8'h08, 32'h3);
		dwic_host_model_i.wr(8'h44, 32'h02);
		line_in[1] = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1 line_in[1] = 1'b0;
		repeat (60) @(posedge ref_clk);
		chk_rd(8'h02, 32'h0, 32'h01);
		line_in[1] = 1'b1;
		repeat (80) @(posedge ref_clk);
		chk_rd(8'h02, 32'h1, 32'h01);
		repeat (3) @(posedge ref_clk);
		$display("test filter done");
		report_and_stop;
	end
endmodule
